/* File: core/qsp_pkg.sv */
// ----------------------------------------------------------------------------
// Shared constants for the burst-of-two DDR static memory port link
// ----------------------------------------------------------------------------
package qsp_pkg;

  // --------------------------------------------------------------------------
  // Widths (wide variant: four nine-bit lanes, 21 address bits)
  // --------------------------------------------------------------------------
  localparam int QSP_LANE_W  = 9;                        // Bits per byte lane
  localparam int QSP_LANES   = 4;                        // Lanes per data word
  localparam int QSP_DATA_W  = QSP_LANE_W * QSP_LANES;   // One data word
  localparam int QSP_BURST_W = 2 * QSP_DATA_W;           // Two-word burst
  localparam int QSP_ADDR_W  = 21;                       // Burst location address
  localparam int QSP_NARROW_ADDR_W = 22;                 // Address width of the 18-bit variant

  // --------------------------------------------------------------------------
  // Storage kept in flip-flops: only the low address bits index it
  // --------------------------------------------------------------------------
  localparam int QSP_IDX_W     = 4;                      // Stored index bits
  localparam int QSP_MEM_DEPTH = 1 << QSP_IDX_W;         // Stored burst locations

  // --------------------------------------------------------------------------
  // Read latency in link halves (one CLK_IN cycle per half)
  // --------------------------------------------------------------------------
  localparam int QSP_RD_LAT_PLL_ON  = 4;                 // Two full link cycles
  localparam int QSP_RD_LAT_PLL_OFF = 2;                 // One full link cycle
  localparam int QSP_PIPE_D         = QSP_RD_LAT_PLL_ON; // Pending read stages

  // --------------------------------------------------------------------------
  // Reset and strap defaults
  // --------------------------------------------------------------------------
  localparam logic QSP_TERM_HIGH_RST = 1'b1;             // Undriven strap means high range
  localparam logic QSP_PLL_ON_RST    = 1'b1;             // Normal PLL-on mode
  localparam logic QSP_SEL_IDLE      = 1'b1;             // Port selects idle high

  // --------------------------------------------------------------------------
  // State encodings
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    QSP_PH_K_HALF  = 2'b01,                              // Positive clock rising half
    QSP_PH_KN_HALF = 2'b10                               // Negative clock rising half
  } qsp_phase_type;

  typedef enum logic [2:0] {
    QSP_RO_IDLE  = 3'b001,                               // Outputs floating
    QSP_RO_WORD0 = 3'b010,                               // First burst word on bus
    QSP_RO_WORD1 = 3'b100                                // Second burst word on bus
  } qsp_rdout_type;

endpackage

/* File: core/qsp_link_if.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Pin-level link between memory controller and memory
// ----------------------------------------------------------------------------
interface qsp_link_if;
  import qsp_pkg::*;
  logic                  k;                         // Positive input clock level
  logic                  k_n;                       // Negative input clock level
  logic                  read_port_select_n;        // Read start, low active
  logic                  write_port_select_n;       // Write start, low active
  logic [QSP_ADDR_W-1:0] addr;                      // Shared address bus
  logic [QSP_DATA_W-1:0] d;                         // Write data bus
  logic [QSP_LANES-1:0]  byte_lane_write_select_n;  // Lane masks, low writes
  logic [QSP_DATA_W-1:0] q;                         // Read data driven value
  logic                  q_oe;                      // Read data output enable
  logic                  read_output_valid;         // Read data valid
  logic                  echo_clock;                // Echo clock
  logic                  echo_clock_n;              // Inverted echo clock
  logic                  termination_range_select;  // Termination strap
  logic                  pll_off_n;                 // PLL off, low active

  modport mem (
    input  k, k_n, read_port_select_n, write_port_select_n, addr, d,
           byte_lane_write_select_n, termination_range_select, pll_off_n,
    output q, q_oe, read_output_valid, echo_clock, echo_clock_n
  );

  modport ctl (
    output k, k_n, read_port_select_n, write_port_select_n, addr, d,
           byte_lane_write_select_n, termination_range_select, pll_off_n,
    input  q, q_oe, read_output_valid, echo_clock, echo_clock_n
  );
endinterface

/* File: core/qsp_mem_end.sv */
`timescale 1ns/1ps
// Contract
// - Write data sampled on both clock edges
// - Low write select at K starts write
// - Deselected write port ignores data, no update
// - Each lane select gates one nine-bit lane
// - Lane selects sampled with their data word
// - Unselected lane keeps its old contents
// - Read address at K, write address at K-bar
// - Address width 22 narrow, 21 wide
// - Deselected port's address is ignored
// - Read words launched on both clock edges
// - Deselected read port floats its outputs
// - Low read select at K starts read
// - Pending read completes before outputs float
// - Each read returns exactly two words
// - Valid flag marks read data, echo aligned
// - Termination strap captured once at initialisation
// - Accesses start only on K rising edge
// - Echo clocks run free, tied to K
// - PLL off selects one-cycle latency mode
module qsp_mem_end
  import qsp_pkg::*;
(
  input  wire logic CLK_IN,                // System clock
  input  wire logic RST_N_IN,              // Synchronous reset, low active
  input  wire logic CE_IN,                 // Clock enable, freezes all state
  qsp_link_if.mem   LINK,                  // Pin side toward the controller
  output logic      TERM_RANGE_HIGH_OUT,   // Captured termination range
  output logic      PLL_BYPASS_MODE_OUT    // High in single-cycle latency mode
);

  // --------------------------------------------------------------------------
  // Half decode
  // --------------------------------------------------------------------------
  // The link clocks arrive from logic on CLK_IN, so their levels name the half
  logic k_half;                                 // Positive clock rising half
  logic kn_half;                                // Negative clock rising half
  logic [QSP_IDX_W-1:0] link_idx;               // Stored index from address bus

  assign k_half   = LINK.k & ~LINK.k_n;
  assign kn_half  = LINK.k_n & ~LINK.k;
  // Only the low bits index the stored locations; upper bits alias
  assign link_idx = LINK.addr[QSP_IDX_W-1:0];

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [QSP_DATA_W-1:0] mem_w0 [QSP_MEM_DEPTH];   // First word of each burst
  logic [QSP_DATA_W-1:0] mem_w1 [QSP_MEM_DEPTH];   // Second word of each burst

  // --------------------------------------------------------------------------
  // Write capture
  // --------------------------------------------------------------------------
  logic                  wr_open_r;             // Write started, awaiting second half
  logic [QSP_DATA_W-1:0] wr_word0_r;            // First write word held
  logic [QSP_LANES-1:0]  wr_lane0_n_r;          // First word lane selects held

  // Write start is only looked at on the positive half
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      wr_open_r <= 1'b0;
    end else if (CE_IN) begin
      if (k_half) begin
        wr_open_r <= ~LINK.write_port_select_n;
      end else begin
        // Burst closes at its second half
        wr_open_r <= 1'b0;
      end
    end
  end

  // First word and its lanes, held until the write address arrives
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      wr_word0_r   <= '0;
      wr_lane0_n_r <= '1;
    end else if (CE_IN) begin
      // Deselected write leaves held data untouched
      if (k_half && !LINK.write_port_select_n) begin
        wr_word0_r   <= LINK.d;
        wr_lane0_n_r <= LINK.byte_lane_write_select_n;
      end
    end
  end

  // Both words land together at the second half, when the write address is known.
  // Storage has no reset: a memory array holds garbage after power-up anyway.
  always_ff @(posedge CLK_IN) begin
    if (CE_IN && RST_N_IN && kn_half && wr_open_r) begin
      for (int l = 0; l < QSP_LANES; l++) begin
        // Lane select low writes the lane, high keeps the old bits
        if (!wr_lane0_n_r[l]) begin
          mem_w0[link_idx][l*QSP_LANE_W +: QSP_LANE_W] <= wr_word0_r[l*QSP_LANE_W +: QSP_LANE_W];
        end
        // Second word uses lane selects sampled beside it
        if (!LINK.byte_lane_write_select_n[l]) begin
          mem_w1[link_idx][l*QSP_LANE_W +: QSP_LANE_W] <= LINK.d[l*QSP_LANE_W +: QSP_LANE_W];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read request pipeline
  // --------------------------------------------------------------------------
  logic [QSP_PIPE_D-1:0] rd_vld_r;              // Pending read per half
  logic [QSP_IDX_W-1:0]  rd_idx_r [QSP_PIPE_D]; // Pending read index per half
  logic                  lat_hit;               // Pending read reaches the bus
  logic [QSP_IDX_W-1:0]  lat_idx;               // Its stored index

  // Read address is taken only at the positive half with read select low
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      rd_vld_r <= '0;
    end else if (CE_IN) begin
      rd_vld_r <= {rd_vld_r[QSP_PIPE_D-2:0], k_half & ~LINK.read_port_select_n};
    end
  end

  // Index shift; stale entries are harmless because the valid bit gates them
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      for (int s = 0; s < QSP_PIPE_D; s++) begin
        rd_idx_r[s] <= '0;
      end
    end else if (CE_IN) begin
      rd_idx_r[0] <= link_idx;
      for (int s = 1; s < QSP_PIPE_D; s++) begin
        rd_idx_r[s] <= rd_idx_r[s-1];
      end
    end
  end

  // Latency tap chosen by the PLL strap
  always_comb begin
    if (LINK.pll_off_n) begin
      lat_hit = rd_vld_r[QSP_RD_LAT_PLL_ON-1];
      lat_idx = rd_idx_r[QSP_RD_LAT_PLL_ON-1];
    end else begin
      lat_hit = rd_vld_r[QSP_RD_LAT_PLL_OFF-1];
      lat_idx = rd_idx_r[QSP_RD_LAT_PLL_OFF-1];
    end
  end

  // --------------------------------------------------------------------------
  // Read output drive
  // --------------------------------------------------------------------------
  qsp_rdout_type         ro_state_r;            // Output burst state
  logic [QSP_IDX_W-1:0]  ro_idx_r;              // Index of burst on the bus
  logic [QSP_DATA_W-1:0] q_r;                   // Read data register
  logic                  q_oe_r;                // Read drive enable
  logic                  vld_r;                 // Read valid flag

  // Array is read at launch time, so a write just before still shows
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      ro_state_r <= QSP_RO_IDLE;
      ro_idx_r   <= '0;
      q_r        <= '0;
      q_oe_r     <= 1'b0;
      vld_r      <= 1'b0;
    end else if (CE_IN) begin
      case (ro_state_r)
        QSP_RO_IDLE, QSP_RO_WORD1: begin
          if (lat_hit) begin
            // First word launched on one half
            ro_state_r <= QSP_RO_WORD0;
            ro_idx_r   <= lat_idx;
            q_r        <= mem_w0[lat_idx];
            q_oe_r     <= 1'b1;
            vld_r      <= 1'b1;
          end else begin
            // Nothing pending: float once the burst has finished
            ro_state_r <= QSP_RO_IDLE;
            q_oe_r     <= 1'b0;
            vld_r      <= 1'b0;
          end
        end
        QSP_RO_WORD0: begin
          // Second word always follows on the other half
          ro_state_r <= QSP_RO_WORD1;
          q_r        <= mem_w1[ro_idx_r];
          q_oe_r     <= 1'b1;
          vld_r      <= 1'b1;
        end
        default: begin
          ro_state_r <= QSP_RO_IDLE;
          q_oe_r     <= 1'b0;
          vld_r      <= 1'b0;
        end
      endcase
    end
  end

  assign LINK.q                 = q_r;
  assign LINK.q_oe              = q_oe_r;
  assign LINK.read_output_valid = vld_r;

  // --------------------------------------------------------------------------
  // Echo clocks
  // --------------------------------------------------------------------------
  logic echo_r;                                 // Echo clock
  logic echo_n_r;                               // Inverted echo clock

  // Runs whatever the read port does; flops keep valid edge aligned to it
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      echo_r   <= 1'b0;
      echo_n_r <= 1'b1;
    end else if (CE_IN) begin
      echo_r   <= k_half;
      echo_n_r <= ~k_half;
    end
  end

  assign LINK.echo_clock   = echo_r;
  assign LINK.echo_clock_n = echo_n_r;

  // --------------------------------------------------------------------------
  // Straps
  // --------------------------------------------------------------------------
  logic strap_done_r;                           // Termination strap taken
  logic term_high_r;                            // Captured termination range
  logic pll_bypass_r;                           // Single-cycle mode indicator

  // Strap is caught on the first enabled edge after reset, never again
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      strap_done_r <= 1'b0;
      term_high_r  <= QSP_TERM_HIGH_RST;
    end else if (CE_IN && !strap_done_r) begin
      strap_done_r <= 1'b1;
      term_high_r  <= LINK.termination_range_select;
    end
  end

  // Mode follows the PLL strap level
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      pll_bypass_r <= ~QSP_PLL_ON_RST;
    end else if (CE_IN) begin
      pll_bypass_r <= ~LINK.pll_off_n;
    end
  end

  assign TERM_RANGE_HIGH_OUT = term_high_r;
  assign PLL_BYPASS_MODE_OUT = pll_bypass_r;

endmodule // qsp_mem_end

/* File: core/qsp_ctl_end.sv */
`timescale 1ns/1ps
module qsp_ctl_end
  import qsp_pkg::*;
(
  input  wire logic                   CLK_IN,        // System clock
  input  wire logic                   RST_N_IN,      // Synchronous reset, low active
  input  wire logic                   CE_IN,         // Clock enable, freezes all state
  qsp_link_if.ctl                     LINK,          // Pin side toward the memory
  output logic                        REQ_READY_OUT, // Requests taken this cycle
  input  wire logic                   RD_REQ_IN,     // Read request
  input  wire logic [QSP_ADDR_W-1:0]  RD_ADDR_IN,    // Read burst address
  input  wire logic                   WR_REQ_IN,     // Write request
  input  wire logic [QSP_ADDR_W-1:0]  WR_ADDR_IN,    // Write burst address
  input  wire logic [QSP_BURST_W-1:0] WR_DATA_IN,    // Word 1 high, word 0 low
  input  wire logic [2*QSP_LANES-1:0] WR_LANE_N_IN,  // Lane selects, word 1 high
  input  wire logic                   TERM_HIGH_IN,  // Termination strap level
  input  wire logic                   PLL_ON_IN,     // PLL strap level
  output logic [QSP_BURST_W-1:0]      RD_DATA_OUT,   // Returned burst
  output logic                        RD_VALID_OUT   // Returned burst pulse
);

  // --------------------------------------------------------------------------
  // Link clock divider
  // --------------------------------------------------------------------------
  qsp_phase_type phase_r;                       // Half now on the link
  logic          k_r;                           // Positive clock level
  logic          k_n_r;                         // Negative clock level
  logic          ready_r;                       // Next edge starts a K half
  logic          take;                          // Requests taken this edge

  assign take = CE_IN && ready_r;

  // Each CLK_IN cycle is one half; two cycles form one link clock period
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      phase_r <= QSP_PH_KN_HALF;
      k_r     <= 1'b0;
      k_n_r   <= 1'b1;
      ready_r <= 1'b1;
    end else if (CE_IN) begin
      case (phase_r)
        QSP_PH_KN_HALF: begin
          phase_r <= QSP_PH_K_HALF;
          k_r     <= 1'b1;
          k_n_r   <= 1'b0;
          ready_r <= 1'b0;
        end
        default: begin
          phase_r <= QSP_PH_KN_HALF;
          k_r     <= 1'b0;
          k_n_r   <= 1'b1;
          ready_r <= 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Command, address and write data launch
  // --------------------------------------------------------------------------
  logic                  rsel_n_r;              // Read select pin
  logic                  wsel_n_r;              // Write select pin
  logic [QSP_ADDR_W-1:0] addr_r;                // Address pins
  logic [QSP_DATA_W-1:0] d_r;                   // Write data pins
  logic [QSP_LANES-1:0]  lane_n_r;              // Lane select pins
  logic [QSP_ADDR_W-1:0] wr_addr_h;             // Write address for second half
  logic [QSP_DATA_W-1:0] wr_word1_h;            // Second write word
  logic [QSP_LANES-1:0]  wr_lane1_h;            // Second word lane selects

  // Selects only ever go low in a K half; second half carries write fields
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      rsel_n_r   <= QSP_SEL_IDLE;
      wsel_n_r   <= QSP_SEL_IDLE;
      addr_r     <= '0;
      d_r        <= '0;
      lane_n_r   <= '1;
      wr_addr_h  <= '0;
      wr_word1_h <= '0;
      wr_lane1_h <= '1;
    end else if (take) begin
      rsel_n_r   <= ~RD_REQ_IN;
      wsel_n_r   <= ~WR_REQ_IN;
      addr_r     <= RD_ADDR_IN;
      d_r        <= WR_DATA_IN[QSP_DATA_W-1:0];
      lane_n_r   <= WR_LANE_N_IN[QSP_LANES-1:0];
      wr_addr_h  <= WR_ADDR_IN;
      wr_word1_h <= WR_DATA_IN[QSP_BURST_W-1:QSP_DATA_W];
      wr_lane1_h <= WR_LANE_N_IN[2*QSP_LANES-1:QSP_LANES];
    end else if (CE_IN) begin
      rsel_n_r   <= QSP_SEL_IDLE;
      wsel_n_r   <= QSP_SEL_IDLE;
      addr_r     <= wr_addr_h;
      d_r        <= wr_word1_h;
      lane_n_r   <= wr_lane1_h;
    end
  end

  // --------------------------------------------------------------------------
  // Straps
  // --------------------------------------------------------------------------
  logic term_r;                                 // Termination strap pin
  logic pll_r;                                  // PLL strap pin

  // Straps follow their levels through reset as well. The memory takes the
  // termination range on its first edge after release, so a reset value here
  // would hide the user's choice from that single capture.
  always_ff @(posedge CLK_IN) begin
    if (CE_IN) begin
      term_r <= TERM_HIGH_IN;
      pll_r  <= PLL_ON_IN;
    end
  end

  // --------------------------------------------------------------------------
  // Read return assembly
  // --------------------------------------------------------------------------
  logic                   got0_r;               // First word already caught
  logic [QSP_BURST_W-1:0] rd_data_r;            // Assembled burst
  logic                   rd_valid_r;           // Burst complete pulse

  // Valid runs two cycles per burst, so word order follows a simple toggle
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      got0_r     <= 1'b0;
      rd_data_r  <= '0;
      rd_valid_r <= 1'b0;
    end else if (CE_IN) begin
      rd_valid_r <= 1'b0;
      if (LINK.read_output_valid) begin
        if (!got0_r) begin
          rd_data_r[QSP_DATA_W-1:0] <= LINK.q;
          got0_r                    <= 1'b1;
        end else begin
          rd_data_r[QSP_BURST_W-1:QSP_DATA_W] <= LINK.q;
          got0_r                              <= 1'b0;
          rd_valid_r                          <= 1'b1;
        end
      end
    end
  end

  assign LINK.k                        = k_r;
  assign LINK.k_n                      = k_n_r;
  assign LINK.read_port_select_n       = rsel_n_r;
  assign LINK.write_port_select_n      = wsel_n_r;
  assign LINK.addr                     = addr_r;
  assign LINK.d                        = d_r;
  assign LINK.byte_lane_write_select_n = lane_n_r;
  assign LINK.termination_range_select = term_r;
  assign LINK.pll_off_n                = pll_r;
  assign REQ_READY_OUT                 = ready_r;
  assign RD_DATA_OUT                   = rd_data_r;
  assign RD_VALID_OUT                  = rd_valid_r;

endmodule // qsp_ctl_end

/* File: dv/qsp_link_properties.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// Link timing checks
// ---------------------------------------------
module qsp_link_properties
  import qsp_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic k,
  input wire logic k_n,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic q_oe,
  input wire logic read_output_valid,
  input wire logic echo_clock,
  input wire logic echo_clock_n,
  input wire logic pll_off_n
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Accesses may only start in a K half
  rsel_in_k_a: assert property (!read_port_select_n |-> k)
    else $error("read select outside K half");
  // Write select is a single K half, then the K-bar half follows
  wsel_pulse_a: assert property (!write_port_select_n |-> k ##1 (k_n && write_port_select_n))
    else $error("write select timing");
  // Clock levels complementary, and a K half is always followed by a K-bar half
  half_alt_a: assert property ((k ^ k_n) and (k |=> k_n))
    else $error("clock halves broken");
  // Echo pair follows K one cycle later
  echo_free_a: assert property (echo_clock == $past(k) && echo_clock_n == !echo_clock)
    else $error("echo clock wrong");
  valid_oe_a: assert property (read_output_valid == q_oe)
    else $error("valid not with data");
  // Two words, five cycles after the K half
  read_burst_a: assert property (!read_port_select_n && pll_off_n |-> ##5 q_oe [*2])
    else $error("read burst late or short");
  // Driving only for a read five or six cycles back; floats otherwise
  read_float_a: assert property (q_oe && pll_off_n |-> $past(!read_port_select_n, 5) || $past(!read_port_select_n, 6))
    else $error("outputs driven without read");
  // Bypass mode answers two cycles sooner
  bypass_lat_a: assert property (!read_port_select_n && !pll_off_n |-> ##3 q_oe [*2])
    else $error("bypass latency wrong");
  rd_c: cover property (!read_port_select_n && pll_off_n);
  wr_c: cover property (!write_port_select_n);
  byp_c: cover property (!read_port_select_n && !pll_off_n);
endmodule // qsp_link_properties

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
  import qsp_pkg::*;
  logic CLK_IN, RST_N_IN, RD_REQ_IN, WR_REQ_IN, TERM_HIGH_IN, PLL_ON_IN;
  logic REQ_READY_OUT, RD_VALID_OUT, TERM_RANGE_HIGH_OUT, PLL_BYPASS_MODE_OUT;
  logic [QSP_ADDR_W-1:0]  RD_ADDR_IN, WR_ADDR_IN;
  logic [QSP_BURST_W-1:0] WR_DATA_IN, RD_DATA_OUT;
  logic [2*QSP_LANES-1:0] WR_LANE_N_IN;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  qsp_link_if link ();
  qsp_mem_end i_qsp_mem_end (.CLK_IN, .RST_N_IN, .CE_IN(1'b1), .LINK(link.mem), .TERM_RANGE_HIGH_OUT,
    .PLL_BYPASS_MODE_OUT);
  qsp_ctl_end i_qsp_ctl_end (.CLK_IN, .RST_N_IN, .CE_IN(1'b1), .LINK(link.ctl), .REQ_READY_OUT, .RD_REQ_IN,
    .RD_ADDR_IN, .WR_REQ_IN, .WR_ADDR_IN, .WR_DATA_IN, .WR_LANE_N_IN, .TERM_HIGH_IN, .PLL_ON_IN, .RD_DATA_OUT,
    .RD_VALID_OUT);
  qsp_link_properties i_qsp_link_properties (.CLK_IN, .RST_N_IN, .k(link.k), .k_n(link.k_n),
    .read_port_select_n(link.read_port_select_n), .write_port_select_n(link.write_port_select_n),
    .q_oe(link.q_oe), .read_output_valid(link.read_output_valid), .echo_clock(link.echo_clock),
    .echo_clock_n(link.echo_clock_n), .pll_off_n(link.pll_off_n));
  initial begin
    CLK_IN = 1'b0;
    forever #5 CLK_IN = ~CLK_IN;
  end
  // Hang guard: the whole run needs well under a few hundred cycles
  always @(posedge CLK_IN) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic chk(input string name, input logic [71:0] exp, input logic [71:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rst(input logic term);
    TERM_HIGH_IN <= term;
    RST_N_IN <= 1'b0;
    repeat (4) @(posedge CLK_IN);
    RST_N_IN <= 1'b1;
    repeat (3) @(posedge CLK_IN);
  endtask
  // Present at the edge that opens a ready cycle, drop at the taking edge
  task automatic req(input logic rd, input logic wr, input logic [20:0] a, input logic [71:0] dat,
    input logic [7:0] ln);
    @(negedge CLK_IN);
    while (REQ_READY_OUT !== 1'b0) @(negedge CLK_IN);
    @(posedge CLK_IN);
    RD_REQ_IN <= rd;
    WR_REQ_IN <= wr;
    RD_ADDR_IN <= a;
    WR_ADDR_IN <= a;
    WR_DATA_IN <= dat;
    WR_LANE_N_IN <= ln;
    @(posedge CLK_IN);
    RD_REQ_IN <= 1'b0;
    WR_REQ_IN <= 1'b0;
  endtask
  // Latency counted in edges from the presenting edge; pipe plus four
  task automatic rd_chk(input logic [20:0] a, input logic [71:0] exp, input int lat);
    int n;
    req(1'b1, 1'b0, a, '0, '0);
    n = 1;
    #1;
    while (RD_VALID_OUT !== 1'b1 && n < 20) begin
      @(posedge CLK_IN);
      #1;
      n++;
    end
    chk("latency", 72'(lat + 4), 72'(n));
    chk("rd_data", exp, RD_DATA_OUT);
  endtask
  function automatic logic [71:0] merge(logic [71:0] old, logic [71:0] nw, logic [7:0] ln);
    merge = old;
    for (int l = 0; l < 8; l++) if (!ln[l]) merge[9*l +: 9] = nw[9*l +: 9];
  endfunction
  task automatic test_strap();
    rst(1'b0);
    chk("term_low", 72'h0, 72'(TERM_RANGE_HIGH_OUT));
    TERM_HIGH_IN <= 1'b1;
    repeat (3) @(posedge CLK_IN);
    chk("term_held", 72'h0, 72'(TERM_RANGE_HIGH_OUT));
    rst(1'b1);
    chk("term_high", 72'h1, 72'(TERM_RANGE_HIGH_OUT));
  endtask
  task automatic test_lanes();
    logic [71:0] a0 = 72'h12_3456_789a_bcde_f012;
    logic [71:0] a1 = 72'hfe_dcba_9876_5432_10ff;
    req(1'b0, 1'b1, 21'h1f0003, a0, 8'h00);
    rd_chk(21'h1f0003, a0, QSP_RD_LAT_PLL_ON);
    req(1'b0, 1'b1, 21'h1f0003, a1, 8'h5a);
    rd_chk(21'h1f0003, merge(a0, a1, 8'h5a), QSP_RD_LAT_PLL_ON);
  endtask
  task automatic test_bypass();
    // Same location as the lane test, so it still holds the merged burst
    logic [71:0] exp_b = merge(72'h12_3456_789a_bcde_f012, 72'hfe_dcba_9876_5432_10ff, 8'h5a);
    @(posedge CLK_IN);
    PLL_ON_IN <= 1'b0;
    repeat (4) @(posedge CLK_IN);
    chk("bypass", 72'h1, 72'(PLL_BYPASS_MODE_OUT));
    rd_chk(21'h1f0003, exp_b, QSP_RD_LAT_PLL_OFF);
    @(posedge CLK_IN);
    PLL_ON_IN <= 1'b1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    {RST_N_IN, RD_REQ_IN, WR_REQ_IN, RD_ADDR_IN, WR_ADDR_IN, WR_DATA_IN} = '0;
    {WR_LANE_N_IN, TERM_HIGH_IN, PLL_ON_IN} = '1;
    test_strap();
    test_lanes();
    test_bypass();
    complete_run();
  end
endmodule // tb
